// File: bbcd_pkg.sv
// package for the branch, bit and control decoder
// assumes a core that supplies fetched bytes, data reads and flag state
package bbcd_pkg;
    localparam logic [3:0] LO_BRANCH_NZ = 4'h0;
    localparam logic [3:0] LO_CALL      = 4'h1;
    localparam logic [3:0] LO_BRANCH_NC = 4'h2;
    localparam logic [3:0] LO_BIT_TEST  = 4'h3;
    localparam logic [3:0] LO_BRANCH_Z  = 4'h4;
    localparam logic [3:0] LO_BRANCH_C  = 4'h6;
    localparam logic [3:0] LO_LONG_JMP  = 4'h9;
    localparam logic [3:0] LO_BIT_OP    = 4'hb;
    localparam logic [3:0] LO_CTRL      = 4'hd;
    localparam logic [7:0] OP_NOP       = 8'h04;
    localparam logic [7:0] OP_RET       = 8'hcd;
    localparam logic [7:0] OP_IRET      = 8'h4d;
    localparam logic [7:0] OP_STOP      = 8'h6d;
    localparam logic [7:0] OP_WAIT      = 8'hed;
    localparam logic [2:0] CYC_SHORT    = 3'h2;
    localparam logic [2:0] CYC_LONG     = 3'h4;
    localparam logic [2:0] CYC_BITTEST  = 3'h5;
    localparam logic [11:0] PC_RESET    = 12'h000;
    localparam int BIT_SEL_LSB          = 5;
    typedef enum {BB_FETCH, BB_ADDR, BB_DISP, BB_WAITDONE} bbcd_state_t;
    typedef struct packed {
        logic        zero;
        logic        carry;
    } bbcd_flags_t;
    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [7:0]  data;
    } bbcd_dwrite_t;
endpackage : bbcd_pkg

// File: bbcd_decoder.sv
// branch, bit manipulation, control and jump/call decoder
// assumes program memory answers fetch address combinationally and data reads likewise
// What this block does
// - flag branches one byte, two cycles, flags kept
// - five bit displacement, reach minus15 to plus16
// - bit test branch three bytes, five cycles
// - tested bit goes into carry, zero kept
// - bit test offset eight bit signed byte
// - opcode bit field plus address byte
// - set/clear bit two bytes four cycles
// - nop and return one byte two cycles
// - interrupt return restores zero and carry
// - stop and wait one byte two cycles
// - watchdog option turns stop into wait
// - twelve bit jump/call two bytes four cycles
// - low nibble selects flag branch or call
// - nibble three selects bit test branch
// - direction bit plus four bit magnitude
// - unassigned codes flagged as illegal
module bbcd_decoder (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic [7:0]            progData,
    input  wire logic [7:0]            dataRdData,
    input  wire bbcd_pkg::bbcd_flags_t flagsIn,
    input  wire bbcd_pkg::bbcd_flags_t savedFlags,
    input  wire logic [11:0]           returnAddr,
    input  wire logic                  watchdogOption,
    output bbcd_pkg::bbcd_flags_t      flagsOut,
    output logic [11:0]                pc,
    output logic [7:0]                 dataRdAddr,
    output bbcd_pkg::bbcd_dwrite_t     dataWr,
    output logic                       pushReturn,
    output logic                       popReturn,
    output logic                       stopMode,
    output logic                       waitMode,
    output logic                       illegalOp,
    output logic                       instrDone
);
    import bbcd_pkg::*;

    localparam logic [2:0] CYC_FINAL = 3'h1;

    // sequencing state
    bbcd_state_t  state, next_state;
    logic [2:0]   cycle, next_cycle;
    logic [7:0]   opcode, next_opcode;
    logic [7:0]   addrByte, next_addrByte;
    logic [11:0]  target, next_target;
    logic [11:0]  next_pc;
    logic [7:0]   next_dataRdAddr;
    logic         next_instrDone;
    // flag state
    bbcd_flags_t  next_flagsOut;
    // data write state
    bbcd_dwrite_t next_dataWr;
    // control outputs
    logic         next_pushReturn;
    logic         next_popReturn;
    logic         next_stopMode;
    logic         next_waitMode;
    logic         next_illegalOp;

    // fetch-time decode of the byte at pc
    logic [3:0]   lo;
    logic         isRelBranch;
    logic         isExtended;
    logic         isCall;
    logic         isBitTest;
    logic         isBitOp;
    logic         isCtrl;
    logic         isRet;
    logic         isIret;
    logic         isStop;
    logic         isWait;
    logic         isIllegal;
    logic         condMet;
    logic [11:0]  span;
    // execute-time decode of the latched opcode
    logic [3:0]   opLo;
    logic         curExtended;
    logic         curCall;
    logic         curBitTest;
    logic         curBitOp;
    logic         curReturn;
    logic [2:0]   bitSel;
    logic         bitVal;
    logic [7:0]   bitMask;
    logic [7:0]   modByte;
    logic [11:0]  dispExt;
    logic         lastCycle;

    assign lo = progData[3:0];
    // every even column is a relative branch; bit 3 is then the low span bit
    assign isRelBranch = (lo[0] == 1'b0);
    assign isCall = (lo == LO_CALL);
    assign isExtended = isCall || (lo == LO_LONG_JMP);
    assign isBitTest = (lo == LO_BIT_TEST);
    assign isBitOp = (lo == LO_BIT_OP);
    assign isCtrl = (lo == LO_CTRL);
    assign isRet = (progData == OP_RET);
    assign isIret = (progData == OP_IRET);
    assign isStop = (progData == OP_STOP);
    assign isWait = (progData == OP_WAIT);
    // whatever no group claims is an unassigned position
    assign isIllegal = !isRelBranch && !isExtended && !isBitTest && !isBitOp &&
                       !(isCtrl && (isRet || isIret || isStop || isWait));
    // no-operation sits in a branch column with zero span: both outcomes land on pc + 1
    assign span = {8'h00, progData[7:5], progData[3]};

    always_comb begin
        condMet = 1'b0;
        case (lo[2:0])
            LO_BRANCH_NZ[2:0]: condMet = !flagsIn.zero;
            LO_BRANCH_NC[2:0]: condMet = !flagsIn.carry;
            LO_BRANCH_Z[2:0]:  condMet = flagsIn.zero;
            LO_BRANCH_C[2:0]:  condMet = flagsIn.carry;
            default:           condMet = 1'b0;
        endcase
    end

    assign opLo = opcode[3:0];
    assign curExtended = (opLo == LO_CALL) || (opLo == LO_LONG_JMP);
    assign curCall = (opLo == LO_CALL);
    assign curBitTest = (opLo == LO_BIT_TEST);
    assign curBitOp = (opLo == LO_BIT_OP);
    assign curReturn = (opcode == OP_RET) || (opcode == OP_IRET);
    assign lastCycle = (cycle == CYC_FINAL);
    // high nibble 0/1 bit0, 2/3 bit4, 4/5 bit2, 6/7 bit6, odd bits above
    assign bitSel = {opcode[5], opcode[6], opcode[7]};
    assign bitVal = dataRdData[bitSel];
    assign dispExt = {{4{progData[7]}}, progData};
    // one lane per data bit: only the selected lane may change
    for (genvar i = 0; i < 8; i++) begin : g_lane
        assign bitMask[i] = (bitSel == 3'(i));
        assign modByte[i] = bitMask[i] ? opcode[4] : dataRdData[i];
    end

    always_comb begin
        next_state = state;
        next_cycle = cycle;
        next_opcode = opcode;
        next_addrByte = addrByte;
        next_target = target;
        next_pc = pc;
        next_dataRdAddr = dataRdAddr;
        next_instrDone = 1'b0;
        case (state)
            BB_FETCH: begin
                next_opcode = progData;
                next_pc = pc + 12'h001;
                next_cycle = CYC_SHORT - 3'h1;
                next_state = BB_WAITDONE;
                if (isExtended) begin
                    next_target = {progData[7:4], 8'h00};
                    next_cycle = CYC_LONG - 3'h1;
                    next_state = BB_ADDR;
                end else if (isBitTest) begin
                    next_cycle = CYC_BITTEST - 3'h1;
                    next_state = BB_ADDR;
                end else if (isBitOp) begin
                    next_cycle = CYC_LONG - 3'h1;
                    next_state = BB_ADDR;
                end else if (isRelBranch && condMet) begin
                    // untaken falls through to pc + 1 with the same two cycles
                    if (progData[4]) begin
                        next_pc = pc - span;
                    end else begin
                        next_pc = pc + span + 12'h001;
                    end
                end
            end
            BB_ADDR: begin
                next_addrByte = progData;
                next_dataRdAddr = progData;
                next_pc = pc + 12'h001;
                next_cycle = cycle - 3'h1;
                if (curExtended) begin
                    next_target = {target[11:8], progData};
                    next_state = BB_WAITDONE;
                end else if (curBitTest) begin
                    next_state = BB_DISP;
                end else begin
                    next_state = BB_WAITDONE;
                end
            end
            BB_DISP: begin
                next_pc = pc + 12'h001;
                next_cycle = cycle - 3'h1;
                // pc holds the displacement byte, two past the opcode
                next_target = pc + dispExt;
                if (bitVal == opcode[4]) begin
                    next_pc = pc + dispExt;
                end
                next_state = BB_WAITDONE;
            end
            BB_WAITDONE: begin
                next_cycle = cycle - 3'h1;
                if (lastCycle) begin
                    if (curExtended) begin
                        next_pc = target;
                    end else if (curReturn) begin
                        next_pc = returnAddr;
                    end
                    next_instrDone = 1'b1;
                    next_state = BB_FETCH;
                end
            end
            default: next_state = BB_FETCH;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= BB_FETCH;
            cycle <= 3'h0;
            opcode <= 8'h00;
            addrByte <= 8'h00;
            target <= 12'h000;
            pc <= PC_RESET;
            dataRdAddr <= 8'h00;
            instrDone <= 1'b0;
        end else begin
            state <= next_state;
            cycle <= next_cycle;
            opcode <= next_opcode;
            addrByte <= next_addrByte;
            target <= next_target;
            pc <= next_pc;
            dataRdAddr <= next_dataRdAddr;
            instrDone <= next_instrDone;
        end
    end

    // flags pass through except where an instruction owns them
    always_comb begin
        next_flagsOut = flagsOut;
        if (state == BB_FETCH) begin
            next_flagsOut = flagsIn;
            if (isIret) begin
                next_flagsOut = savedFlags;
            end
        end else if (state == BB_DISP) begin
            next_flagsOut.carry = bitVal;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flagsOut <= '0;
        end else begin
            flagsOut <= next_flagsOut;
        end
    end

    // read-modify-write of the addressed byte in the closing cycle
    always_comb begin
        next_dataWr = '0;
        if (state == BB_WAITDONE && lastCycle && curBitOp) begin
            next_dataWr.valid = 1'b1;
            next_dataWr.addr = addrByte;
            next_dataWr.data = modByte;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dataWr <= '0;
        end else begin
            dataWr <= next_dataWr;
        end
    end

    always_comb begin
        next_pushReturn = 1'b0;
        next_popReturn = 1'b0;
        next_stopMode = stopMode;
        next_waitMode = waitMode;
        next_illegalOp = 1'b0;
        if (state == BB_FETCH) begin
            next_popReturn = isRet || isIret;
            next_illegalOp = isIllegal;
            if (isStop) begin
                // a frozen clock would freeze the watchdog too, so stop degrades to wait
                if (watchdogOption) begin
                    next_waitMode = 1'b1;
                end else begin
                    next_stopMode = 1'b1;
                end
            end else if (isWait) begin
                next_waitMode = 1'b1;
            end
        end
        if (state == BB_WAITDONE && lastCycle && curCall) begin
            next_pushReturn = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pushReturn <= 1'b0;
            popReturn <= 1'b0;
            stopMode <= 1'b0;
            waitMode <= 1'b0;
            illegalOp <= 1'b0;
        end else begin
            pushReturn <= next_pushReturn;
            popReturn <= next_popReturn;
            stopMode <= next_stopMode;
            waitMode <= next_waitMode;
            illegalOp <= next_illegalOp;
        end
    end
endmodule : bbcd_decoder

// File: bbcd_decoder_asserts.sv
// checker for the branch, bit and control decoder
// assumes one clock domain, bound onto bbcd_decoder
module bbcd_decoder_asserts
    import bbcd_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst_n,
    input wire logic         watchdogOption,
    input wire bbcd_dwrite_t dataWr,
    input wire logic         pushReturn,
    input wire logic         popReturn,
    input wire logic         stopMode,
    input wire logic         waitMode,
    input wire logic         illegalOp,
    input wire logic         instrDone
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_done_pulse: assert property (instrDone |=> !instrDone) else $error("done wider than one cycle");
    a_illegal_done: assert property (illegalOp |-> ##[0:1] instrDone) else $error("illegal code not short");
    a_illegal_quiet: assert property (illegalOp |-> !dataWr.valid && !pushReturn && !popReturn)
        else $error("illegal code had side effect");
    a_wait_sticky: assert property (waitMode |=> waitMode) else $error("wait mode dropped");
    a_stop_sticky: assert property (stopMode |=> stopMode) else $error("stop mode dropped");
    a_stop_watchdog: assert property (watchdogOption |-> !$rose(stopMode)) else $error("stop under watchdog");
    a_push_done: assert property (pushReturn |-> instrDone) else $error("push not at call end");
    a_write_done: assert property (dataWr.valid |-> ##[0:2] instrDone) else $error("write not near end");
    a_pop_done: assert property (popReturn |-> ##1 instrDone) else $error("return not two cycles");
endmodule : bbcd_decoder_asserts

bind bbcd_decoder bbcd_decoder_asserts u_chk (.clk_sys, .rst_n, .watchdogOption, .dataWr, .pushReturn,
    .popReturn, .stopMode, .waitMode, .illegalOp, .instrDone);

// File: test_branch_bit_control_decoder.sv
// testbench for the branch, bit and control decoder
// assumes program memory and one data byte answer combinationally
module test_branch_bit_control_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    import bbcd_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   rom [0:4095];
    logic [7:0]   dmem = 8'h00;
    logic [7:0]   progData, dataRdData, dataRdAddr;
    bbcd_flags_t  flagsIn = 2'b00, savedFlags = 2'b11, flagsOut;
    logic [11:0]  returnAddr = 12'h0a5, pc;
    logic         watchdogOption = 1'b1, pushReturn, popReturn, stopMode, waitMode, illegalOp, instrDone;
    logic         sawIllegal = 1'b0;
    bbcd_dwrite_t dataWr;
    int           mismatches = 0, n_compared = 0, cycles = 0;
    // one data byte for every address keeps the model small
    assign progData = rom[pc];
    assign dataRdData = dmem;
    bbcd_decoder dut (.clk_sys, .rst_n, .progData, .dataRdData, .flagsIn, .savedFlags, .returnAddr,
        .watchdogOption, .flagsOut, .pc, .dataRdAddr, .dataWr, .pushReturn, .popReturn, .stopMode,
        .waitMode, .illegalOp, .instrDone);
    initial forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (illegalOp === 1'b1) sawIllegal <= 1'b1;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    task chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task reset_dut();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        chk("pc after reset", pc, PC_RESET);
    endtask : reset_dut
    // places up to three bytes at pc, then times the instruction
    task step(input logic [7:0] b0, b1, b2, input int cyc, input logic [11:0] npc);
        int n;
        rom[pc] = b0;
        rom[pc + 12'h1] = b1;
        rom[pc + 12'h2] = b2;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (instrDone !== 1'b1 && n < 8);
        chk("cycles", n, cyc);
        chk("pc", pc, npc);
    endtask : step
    task t_branch();
        flagsIn <= 2'b01;
        step(8'h24, 8'h00, 8'h00, 2, pc + 12'h1);
        chk("flags", flagsOut, 2'b01);
        step(8'h10, 8'h00, 8'h00, 2, pc);
        step(8'hf8, 8'h00, 8'h00, 2, pc - 12'd15);
        step(8'he8, 8'h00, 8'h00, 2, pc + 12'd16);
    endtask : t_branch
    task t_jump();
        step(8'h59, 8'h3c, 8'h00, 4, 12'h53c);
        step(8'h21, 8'h00, 8'h00, 4, 12'h200);
        chk("push", pushReturn, 1'b1);
        step(OP_RET, 8'h00, 8'h00, 2, returnAddr);
        step(OP_NOP, 8'h00, 8'h00, 2, pc + 12'h1);
        step(OP_IRET, 8'h00, 8'h00, 2, returnAddr);
        chk("restored flags", flagsOut, savedFlags);
    endtask : t_jump
    task t_bittest();
        flagsIn <= 2'b11;
        dmem = 8'hfe;
        step(8'h13, 8'h30, 8'h40, 5, pc + 12'h3);
        chk("tested bit", flagsOut, 2'b10);
        step(8'h03, 8'h30, 8'h7f, 5, pc + 12'd129);
        chk("carry from bit", flagsOut.carry, 1'b0);
    endtask : t_bittest
    task t_bitop();
        dmem = 8'h00;
        step(8'h7b, 8'h20, 8'h00, 4, pc + 12'h2);
        chk("set write", dataWr, {1'b1, 8'h20, 8'h40});
        dmem = 8'hff;
        step(8'h6b, 8'h41, 8'h00, 4, pc + 12'h2);
        chk("clear write", dataWr, {1'b1, 8'h41, 8'hbf});
    endtask : t_bitop
    task t_illegal();
        step(8'h05, 8'h00, 8'h00, 2, pc + 12'h1);
        chk("illegal seen", sawIllegal, 1'b1);
    endtask : t_illegal
    task t_stop();
        step(OP_STOP, 8'h00, 8'h00, 2, pc + 12'h1);
        chk("modes", {stopMode, waitMode}, 2'b01);
        watchdogOption <= 1'b0;
        reset_dut();
        step(OP_WAIT, 8'h00, 8'h00, 2, pc + 12'h1);
        step(OP_STOP, 8'h00, 8'h00, 2, pc + 12'h1);
        chk("modes", {stopMode, waitMode}, 2'b11);
    endtask : t_stop
    task conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial begin
        foreach (rom[i]) rom[i] = 8'h05;
        reset_dut();
        t_branch();
        t_jump();
        t_bittest();
        t_bitop();
        t_illegal();
        t_stop();
        conclude();
    end
endmodule : test_branch_bit_control_decoder
